// ==== flash_host_pkg.sv ====
// Constants, command codes and types shared by the flash command host
package flash_host_pkg;

  // Bus cycle timing, figures in ns and derived clock counts (rounded up)
  localparam int CLK_PERIOD_NS   = 100;
  localparam int ADDR_SETUP_NS   = 50;
  localparam int WE_PULSE_NS     = 35;
  localparam int DATA_HOLD_NS    = 30;
  localparam int READ_ACCESS_NS  = 70;
  localparam int RECOVERY_NS     = 30;
  localparam logic [3:0] ADDR_SETUP_CYC  = 4'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WE_PULSE_CYC    = 4'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] DATA_HOLD_CYC   = 4'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_ACCESS_CYC = 4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOVERY_CYC    = 4'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Command cycle addresses and data (word-mode addresses)
  localparam logic [11:0] UNLOCK1_ADDR   = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR   = 12'h2aa;
  localparam logic [11:0] QUERY_ADDR     = 12'h055;
  localparam logic [7:0]  UNLOCK1_DATA   = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
  localparam logic [7:0]  AUTOSEL_DATA   = 8'h90;
  localparam logic [7:0]  SEC_ENTER_DATA = 8'h88;
  localparam logic [7:0]  SEC_EXIT_DATA  = 8'h90;
  localparam logic [7:0]  SEC_EXIT_LAST  = 8'h00;
  localparam logic [7:0]  BYPASS_DATA    = 8'h20;
  localparam logic [7:0]  RESET_DATA     = 8'hf0;
  localparam logic [7:0]  QUERY_DATA     = 8'h98;
  localparam logic [7:0]  PROT_OFFSET    = 8'h02;

  // Query table word addresses
  localparam logic [7:0] GEO_SIZE_ADDR   = 8'h27;
  localparam logic [7:0] GEO_REGION_ADDR = 8'h2c;
  localparam logic [7:0] GEO_BANKS_ADDR  = 8'h57;
  localparam logic [7:0] GEO_BANK0_ADDR  = 8'h58;
  localparam logic [3:0] GEO_LAST_STEP   = 4'h8;

  localparam int TIMEOUT_BIT = 5;

  typedef enum logic [3:0] {
    CMD_READ      = 4'h0,
    CMD_WRITE     = 4'h1,
    CMD_RESET     = 4'h2,
    CMD_AUTOSEL   = 4'h3,
    CMD_PROT      = 4'h4,
    CMD_SEC_ENTER = 4'h5,
    CMD_SEC_EXIT  = 4'h6,
    CMD_QUERY     = 4'h7,
    CMD_GEOMETRY  = 4'h8,
    CMD_POLL      = 4'h9,
    CMD_BYPASS    = 4'ha
  } cmd_t;

  typedef enum logic [1:0] {
    MODE_ARRAY   = 2'b00,
    MODE_AUTOSEL = 2'b01,
    MODE_QUERY   = 2'b11,
    MODE_SECURED = 2'b10
  } mode_t;

endpackage

// ==== bus_cycle_if.sv ====
// Request/answer carrier between the command sequencer and the bus cycle engine
`timescale 1ns/1ps
interface bus_cycle_if #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport issuer (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ==== flash_bus_cycle.sv ====
// One asynchronous flash bus cycle (write or read) on chip select and strobes
`timescale 1ns/1ps
module flash_bus_cycle #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  bus_cycle_if.engine            bus,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_we_n_o,
  output logic                   flash_oe_n_o
);

  // Gray path so strobe decodes change one state bit per step, except RECOV back to IDLE, which changes two
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_RECOV  = 3'b110
  } cyc_state_t;

  cyc_state_t        state;
  cyc_state_t        next_state;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic              is_wr;
  logic [DATA_W-1:0] rdata;
  wire               phase_end = (cnt == 4'h1);
  wire               start     = bus.req && (state == ST_IDLE);

  always_comb begin
    next_state = state;
    next_cnt   = cnt - 4'h1;
    unique case (state)
      ST_IDLE: begin
        next_cnt = 4'h0;
        if (bus.req) begin
          next_state = ST_SETUP;
          next_cnt   = flash_host_pkg::ADDR_SETUP_CYC;
        end
      end
      ST_SETUP: if (phase_end) begin
        next_state = ST_STROBE;
        next_cnt   = is_wr ? flash_host_pkg::WE_PULSE_CYC : flash_host_pkg::READ_ACCESS_CYC;
      end
      ST_STROBE: if (phase_end) begin
        next_state = ST_HOLD;
        next_cnt   = flash_host_pkg::DATA_HOLD_CYC;
      end
      ST_HOLD: if (phase_end) begin
        next_state = ST_RECOV;
        next_cnt   = flash_host_pkg::RECOVERY_CYC;
      end
      ST_RECOV: if (phase_end) begin
        next_state = ST_IDLE;
        next_cnt   = 4'h0;
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      is_wr        <= 1'b0;
      flash_addr_o <= '0;
      flash_dq_o   <= '0;
    end else if (start) begin
      is_wr        <= bus.wr;
      flash_addr_o <= bus.addr;
      flash_dq_o   <= bus.wdata;
    end
  end

  // Sample at the end of the access window while output enable is still low
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata <= '0;
    end else if (state == ST_STROBE && phase_end && !is_wr) begin
      rdata <= flash_dq_i;
    end
  end

  // Select falls a phase before the write strobe and rises a phase after it
  assign flash_ce_n_o  = !(state == ST_SETUP || state == ST_STROBE || state == ST_HOLD);
  assign flash_we_n_o  = !(is_wr && state == ST_STROBE);
  assign flash_oe_n_o  = !(!is_wr && state == ST_STROBE);
  assign flash_dq_oe_o = is_wr && !flash_ce_n_o;
  assign bus.done      = (state == ST_RECOV) && phase_end;
  assign bus.rdata     = rdata;

  a_we_inside_ce: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(flash_we_n_o) |-> !flash_ce_n_o && $past(!flash_ce_n_o))
    else $error("write strobe fell without select already low");

  a_we_rises_first: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(flash_we_n_o) |-> !flash_ce_n_o && flash_dq_oe_o ##1 flash_ce_n_o)
    else $error("write strobe rise without data driven or select rising after");

endmodule // flash_bus_cycle

// ==== flash_cmd_host.sv ====
// Host-side command sequencer that drives a multi-bank flash through its pins
`timescale 1ns/1ps
module flash_cmd_host #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic [3:0]        cmd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              byte_mode_i,
  input  wire logic              device_ready_i,
  output logic                   done_o,
  output logic                   refused_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             mode_o,
  output logic [7:0]             geo_size_exp_o,
  output logic [7:0]             geo_region_cnt_o,
  output logic [7:0]             geo_bank_cnt_o,
  output logic [31:0]            geo_bank_sectors_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_we_n_o,
  output logic                   flash_oe_n_o
);

  typedef struct packed {
    logic              last;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } step_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ISSUE = 2'b01,
    S_WAIT  = 2'b11
  } seq_state_t;

  seq_state_t            st;
  flash_host_pkg::cmd_t  cmd_q;
  flash_host_pkg::mode_t mode;
  flash_host_pkg::mode_t next_mode;
  logic [ADDR_W-1:0]     addr_q;
  logic [DATA_W-1:0]     wdata_q;
  logic [3:0]            idx;
  logic                  pend_reset;
  logic [7:0]            geo [0:6];
  step_t                 cur;

  bus_cycle_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bus ();

  // Command addresses are word addresses; byte mode doubles them
  function automatic logic [ADDR_W-1:0] cad(input logic [11:0] a, input logic bm);
    cad = bm ? ADDR_W'({a, 1'b0}) : ADDR_W'(a);
  endfunction

  function automatic step_t seq_step(input flash_host_pkg::cmd_t c, input logic [3:0] i,
                                     input flash_host_pkg::mode_t m, input logic [ADDR_W-1:0] ua,
                                     input logic [DATA_W-1:0] ud, input logic bm);
    step_t             s;
    logic [ADDR_W-1:0] u1;
    s    = '{last: 1'b1, wr: 1'b1, addr: ua, data: ud};
    u1   = cad(flash_host_pkg::UNLOCK1_ADDR, bm);
    case (c)
      flash_host_pkg::CMD_READ, flash_host_pkg::CMD_POLL: begin
        // Leaving autoselect or query needs a reset before array reads
        if (c == flash_host_pkg::CMD_READ && i == 4'h0 && m inside {flash_host_pkg::MODE_AUTOSEL,
            flash_host_pkg::MODE_QUERY}) begin
          s.last = 1'b0;
          s.data = DATA_W'(flash_host_pkg::RESET_DATA);
        end else begin
          s.wr = 1'b0;
        end
      end
      flash_host_pkg::CMD_WRITE: s.wr = 1'b1;
      flash_host_pkg::CMD_RESET: s.data = DATA_W'(flash_host_pkg::RESET_DATA);
      flash_host_pkg::CMD_PROT: begin
        s.wr   = 1'b0;
        s.addr = {ua[ADDR_W-1:8], flash_host_pkg::PROT_OFFSET};
      end
      flash_host_pkg::CMD_QUERY: begin
        s.addr = cad(flash_host_pkg::QUERY_ADDR, bm);
        s.data = DATA_W'(flash_host_pkg::QUERY_DATA);
      end
      flash_host_pkg::CMD_GEOMETRY: begin
        s.last = (i == flash_host_pkg::GEO_LAST_STEP);
        if (i == 4'h0) begin
          s.addr = cad(flash_host_pkg::QUERY_ADDR, bm);
          s.data = DATA_W'(flash_host_pkg::QUERY_DATA);
        end else if (s.last) begin
          s.data = DATA_W'(flash_host_pkg::RESET_DATA);
        end else begin
          s.wr = 1'b0;
          unique case (i)
            4'h1:    s.addr = cad({4'h0, flash_host_pkg::GEO_SIZE_ADDR}, bm);
            4'h2:    s.addr = cad({4'h0, flash_host_pkg::GEO_REGION_ADDR}, bm);
            4'h3:    s.addr = cad({4'h0, flash_host_pkg::GEO_BANKS_ADDR}, bm);
            default: s.addr = cad({4'h0, flash_host_pkg::GEO_BANK0_ADDR + 8'(i - 4'h4)}, bm);
          endcase
        end
      end
      default: begin
        // Unlock pair, then the command cycle; exit takes a fourth write
        s.last = (c == flash_host_pkg::CMD_SEC_EXIT) ? (i == 4'h3) : (i == 4'h2);
        unique case (i)
          4'h0: begin
            s.addr = u1;
            s.data = DATA_W'(flash_host_pkg::UNLOCK1_DATA);
          end
          4'h1: begin
            s.addr = cad(flash_host_pkg::UNLOCK2_ADDR, bm);
            s.data = DATA_W'(flash_host_pkg::UNLOCK2_DATA);
          end
          4'h2: begin
            s.addr = u1;
            unique case (c)
              flash_host_pkg::CMD_AUTOSEL: begin
                s.addr = {ua[ADDR_W-1:ADDR_W-2], u1[ADDR_W-3:0]};
                s.data = DATA_W'(flash_host_pkg::AUTOSEL_DATA);
              end
              flash_host_pkg::CMD_SEC_ENTER: s.data = DATA_W'(flash_host_pkg::SEC_ENTER_DATA);
              flash_host_pkg::CMD_SEC_EXIT:  s.data = DATA_W'(flash_host_pkg::SEC_EXIT_DATA);
              default:                       s.data = DATA_W'(flash_host_pkg::BYPASS_DATA);
            endcase
          end
          default: begin
            s.addr = '0;
            s.data = DATA_W'(flash_host_pkg::SEC_EXIT_LAST);
          end
        endcase
      end
    endcase
    return s;
  endfunction

  wire  take     = cmd_valid_i && cmd_ready_o;
  wire  cmd_busy = (cmd_i == 4'(flash_host_pkg::CMD_AUTOSEL)) || (cmd_i == 4'(flash_host_pkg::CMD_SEC_ENTER))
                   || (cmd_i == 4'(flash_host_pkg::CMD_QUERY)) || (cmd_i == 4'(flash_host_pkg::CMD_GEOMETRY));
  wire  refuse   = (cmd_busy && !device_ready_i)
                   || (cmd_i == 4'(flash_host_pkg::CMD_BYPASS) && mode == flash_host_pkg::MODE_SECURED)
                   || (cmd_i == 4'(flash_host_pkg::CMD_PROT) && mode != flash_host_pkg::MODE_AUTOSEL)
                   || (cmd_i > 4'(flash_host_pkg::CMD_BYPASS));
  wire  step_end = (st == S_WAIT) && bus.done;
  wire  seq_end  = step_end && cur.last;
  wire  timeout  = step_end && cmd_q == flash_host_pkg::CMD_POLL
                   && bus.rdata[flash_host_pkg::TIMEOUT_BIT] && !device_ready_i;

  assign cur         = seq_step(cmd_q, idx, mode, addr_q, wdata_q, byte_mode_i);
  assign cmd_ready_o = (st == S_IDLE) && !pend_reset;
  assign bus.req     = (st == S_ISSUE);
  assign bus.wr      = cur.wr;
  assign bus.addr    = cur.addr;
  assign bus.wdata   = cur.data;
  assign mode_o      = mode;

  // Secured mapping survives resets; the exit, autoselect and query sequences replace it
  always_comb begin
    next_mode = mode;
    unique case (cmd_q)
      flash_host_pkg::CMD_AUTOSEL:   next_mode = flash_host_pkg::MODE_AUTOSEL;
      flash_host_pkg::CMD_SEC_ENTER: next_mode = flash_host_pkg::MODE_SECURED;
      flash_host_pkg::CMD_SEC_EXIT:  next_mode = flash_host_pkg::MODE_ARRAY;
      flash_host_pkg::CMD_QUERY:     next_mode = flash_host_pkg::MODE_QUERY;
      flash_host_pkg::CMD_READ, flash_host_pkg::CMD_RESET, flash_host_pkg::CMD_GEOMETRY:
        if (mode != flash_host_pkg::MODE_SECURED) next_mode = flash_host_pkg::MODE_ARRAY;
      default: next_mode = mode;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st    <= S_IDLE;
      idx   <= 4'h0;
      cmd_q <= flash_host_pkg::CMD_READ;
    end else begin
      unique case (st)
        S_IDLE: begin
          idx <= 4'h0;
          if (pend_reset) begin
            cmd_q <= flash_host_pkg::CMD_RESET;
            st    <= S_ISSUE;
          end else if (take && !refuse) begin
            cmd_q <= flash_host_pkg::cmd_t'(cmd_i);
            st    <= S_ISSUE;
          end
        end
        S_ISSUE: st <= S_WAIT;
        S_WAIT: if (bus.done) begin
          st  <= cur.last ? S_IDLE : S_ISSUE;
          idx <= idx + 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (take) begin
      addr_q  <= addr_i;
      wdata_q <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode       <= flash_host_pkg::MODE_ARRAY;
      pend_reset <= 1'b0;
      done_o     <= 1'b0;
      refused_o  <= 1'b0;
    end else begin
      done_o     <= seq_end;
      refused_o  <= take && refuse;
      pend_reset <= timeout || (pend_reset && st != S_IDLE);
      if (seq_end) mode <= next_mode;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
      for (int k = 0; k < 7; k++) geo[k] <= 8'h00;
    end else if (step_end && !cur.wr) begin
      rdata_o <= bus.rdata;
      if (cmd_q == flash_host_pkg::CMD_GEOMETRY) geo[3'(idx - 4'h1)] <= bus.rdata[7:0];
    end
  end

  assign geo_size_exp_o     = geo[0];
  assign geo_region_cnt_o   = geo[1];
  assign geo_bank_cnt_o     = geo[2];
  assign geo_bank_sectors_o = {geo[6], geo[5], geo[4], geo[3]};

  flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .ref_clk_i     (ref_clk_i),
    .nrst_i        (nrst_i),
    .bus           (bus.engine),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_dq_i    (flash_dq_i),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_oe_n_o  (flash_oe_n_o)
  );

  sequence timeout_seen;
    timeout;
  endsequence
  sequence reset_launched;
    pend_reset ##[1:3] (st == S_ISSUE && cmd_q == flash_host_pkg::CMD_RESET);
  endsequence

  a_timeout_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    timeout_seen |=> reset_launched)
    else $error("timeout bit seen but no reset written");

  a_autosel_leave: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st == S_ISSUE && cmd_q == flash_host_pkg::CMD_READ && idx == 4'h0 && mode == flash_host_pkg::MODE_AUTOSEL
    |-> bus.wr && bus.wdata[7:0] == flash_host_pkg::RESET_DATA)
    else $error("array read from autoselect without reset");

  a_busy_refused: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    take && cmd_i == 4'(flash_host_pkg::CMD_AUTOSEL) && !device_ready_i |=> refused_o && st == S_IDLE)
    else $error("autoselect issued while device busy");

  a_autosel_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $changed(mode) && mode == flash_host_pkg::MODE_AUTOSEL
    |-> $past(cmd_q) == flash_host_pkg::CMD_AUTOSEL && $past(idx) == 4'h2)
    else $error("autoselect mode without three-write entry");

  a_prot_address: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st == S_ISSUE && cmd_q == flash_host_pkg::CMD_PROT
    |-> !bus.wr && bus.addr == {addr_q[ADDR_W-1:8], flash_host_pkg::PROT_OFFSET})
    else $error("protection read lacks sector address");

  a_secured_exit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(mode == flash_host_pkg::MODE_SECURED)
    |-> $past(cmd_q) == flash_host_pkg::CMD_SEC_EXIT && $past(idx) == 4'h3)
    else $error("secured region left without four-write exit");

  a_reset_restores: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    seq_end && cmd_q == flash_host_pkg::CMD_RESET && mode != flash_host_pkg::MODE_SECURED
    |=> mode == flash_host_pkg::MODE_ARRAY && done_o)
    else $error("reset did not restore array mode");

endmodule // flash_cmd_host

// ==== flash_dev_model.sv ====
// Pin-level behavioural flash device facing the command host
`timescale 1ns/1ps
module flash_dev_model (
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        byte_mode_i,
  input  wire logic        busy_i,
  input  wire logic        timeout_i,
  output logic [15:0]      dq_o,
  output logic [1:0]       mode_o
);
  logic [21:0] lat_a;
  logic [15:0] last = 16'h0000;
  logic [15:0] val;
  logic [1:0]  step = 2'd0;
  wire         wr_n = ce_n_i | we_n_i;
  wire  [21:0] wa = byte_mode_i ? lat_a >> 1 : lat_a;
  wire  [21:0] ra = byte_mode_i ? addr_i >> 1 : addr_i;
  wire  [7:0]  d = dq_i[7:0];
  initial mode_o = 2'b00;
  always @(negedge wr_n) lat_a = addr_i;
  // Writes during a run are dropped unless the timeout flag invites a reset
  always @(posedge wr_n) begin
    if (busy_i && !timeout_i) step = 2'd0;
    else if (d == 8'hf0) begin
      step = 2'd0;
      if (mode_o != 2'b10) mode_o = 2'b00;
    end else if (step == 2'd3) begin
      step = 2'd0;
      if (d == 8'h00) mode_o = 2'b00;
    end else if (step == 2'd2) begin
      step = (d == 8'h90 && mode_o == 2'b10) ? 2'd3 : 2'd0;
      if (d == 8'h90 && mode_o != 2'b10) mode_o = 2'b01;
      if (d == 8'h88) mode_o = 2'b10;
    end else if (wa[11:0] == 12'h555 && d == 8'haa) step = 2'd1;
    else if (step == 2'd1 && wa[11:0] == 12'h2aa && d == 8'h55) step = 2'd2;
    else begin
      step = 2'd0;
      if (wa[11:0] == 12'h055 && d == 8'h98) mode_o = 2'b11;
    end
  end
  always_comb begin
    val = ra[15:0] ^ 16'h5a5a;
    if (busy_i) val = {10'h000, timeout_i, 5'h00};
    else if (mode_o == 2'b10) val = ra[15:0] ^ 16'ha5a5;
    else if (mode_o == 2'b01) val = {15'h0000, ra[7:0] == 8'h02};
    else if (mode_o == 2'b11) case (ra[7:0])
      8'h27, 8'h58, 8'h5b: val = 16'h0017;
      8'h2c: val = 16'h0003;
      8'h57: val = 16'h0004;
      8'h59, 8'h5a: val = 16'h0030;
      default: val = 16'h0000;
    endcase
  end
  always @(posedge oe_n_i) last = val;
  // Released bus shows the inverse of the last word, never a stale match
  assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
endmodule // flash_dev_model

// ==== tb_top.sv ====
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [3:0] c; logic [21:0] a; logic rf; logic [1:0] m; logic cr; logic [15:0] d; int lat;} row_t;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        byte_mode = 1'b0;
  logic        busy = 1'b0;
  logic        timeout = 1'b0;
  logic [3:0]  cmd = 4'h0;
  logic [21:0] addr = 22'h000000;
  logic        ready, done, refused, ce_n, we_n, oe_n, dq_oe;
  logic [1:0]  mode, dev_mode;
  logic [15:0] rdata, host_dq, dev_dq;
  logic [21:0] fl_addr;
  logic [7:0]  g_size, g_reg, g_banks;
  logic [31:0] g_sec;
  int          n_fail = 0;
  int          check_count = 0;
  int          lat;
  row_t        rows[16];
  logic [3:0]  busy_cmds[4] = '{4'h3, 4'h5, 4'h7, 4'h8};
  wire  [15:0] dq_bus = dq_oe ? host_dq : dev_dq;
  flash_cmd_host flash_cmd_host_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(ready), .cmd_i(cmd), .addr_i(addr), .wdata_i(16'h1234), .byte_mode_i(byte_mode),
    .device_ready_i(!busy), .done_o(done), .refused_o(refused), .rdata_o(rdata), .mode_o(mode),
    .geo_size_exp_o(g_size), .geo_region_cnt_o(g_reg), .geo_bank_cnt_o(g_banks), .geo_bank_sectors_o(g_sec),
    .flash_addr_o(fl_addr), .flash_dq_o(host_dq), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_bus),
    .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
  flash_dev_model flash_dev_model_i (.addr_i(fl_addr), .dq_i(dq_bus), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .byte_mode_i(byte_mode), .busy_i(busy), .timeout_i(timeout), .dq_o(dev_dq), .mode_o(dev_mode));
  always #50 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_end;
    lat = 0;
    while (done !== 1'b1 && refused !== 1'b1 && lat < 400) begin
      @(posedge ref_clk_i) #1;
      lat++;
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [21:0] a);
    // Always let an edge pass so valid never toggles twice in one step
    do @(posedge ref_clk_i) #1; while (ready !== 1'b1);
    cmd = c;
    addr = a;
    cmd_valid = 1'b1;
    @(posedge ref_clk_i) #1 cmd_valid = 1'b0;
    wait_end();
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #(100 * 3000);
    n_fail++;
    summarize();
  end
  initial begin
    rows = '{'{4'h0, 22'h000123, 1'b0, 2'b00, 1'b1, 16'h5b79, 5},
      '{4'h1, 22'h000040, 1'b0, 2'b00, 1'b0, 16'h0000, 5},
      '{4'h4, 22'h000000, 1'b1, 2'b00, 1'b0, 16'h0000, 0},
      '{4'h3, 22'h100000, 1'b0, 2'b01, 1'b0, 16'h0000, 15},
      '{4'h4, 22'h104500, 1'b0, 2'b01, 1'b1, 16'h0001, 5},
      '{4'h4, 22'h104500, 1'b0, 2'b01, 1'b1, 16'h0001, 5},
      '{4'h2, 22'h3fffff, 1'b0, 2'b00, 1'b0, 16'h0000, 5},
      '{4'h5, 22'h000000, 1'b0, 2'b10, 1'b0, 16'h0000, 15},
      '{4'ha, 22'h000000, 1'b1, 2'b10, 1'b0, 16'h0000, 0},
      '{4'h0, 22'h000010, 1'b0, 2'b10, 1'b1, 16'ha5b5, 5},
      '{4'h6, 22'h000000, 1'b0, 2'b00, 1'b0, 16'h0000, 20},
      '{4'h7, 22'h000000, 1'b0, 2'b11, 1'b0, 16'h0000, 5},
      '{4'h2, 22'h000000, 1'b0, 2'b00, 1'b0, 16'h0000, 5},
      '{4'hb, 22'h000000, 1'b1, 2'b00, 1'b0, 16'h0000, 0},
      '{4'h3, 22'h100000, 1'b0, 2'b01, 1'b0, 16'h0000, 15},
      '{4'h0, 22'h104500, 1'b0, 2'b00, 1'b1, 16'h1f5a, 10}};
    // Flops only take reset at a clock edge here, so look after a few
    repeat (4) @(posedge ref_clk_i);
    #1 chk({ce_n, we_n, oe_n, dq_oe, ready, done, refused, mode}, 32'h000001d0);
    nrst_i = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      issue(rows[i].c, rows[i].a);
      chk({31'h0, refused}, {31'h0, rows[i].rf});
      chk(lat, rows[i].lat);
      chk({mode, dev_mode}, {rows[i].m, rows[i].m});
      if (rows[i].cr) chk(rdata, rows[i].d);
    end
    $display("test table done");
    for (int b = 0; b < 2; b++) begin
      byte_mode = b[0];
      issue(4'h8, 22'h000000);
      chk(lat, 45);
      chk({g_size, g_reg, g_banks, dev_mode}, {24'h170304, 2'b00});
      chk(g_sec, 32'h17303017);
    end
    byte_mode = 1'b0;
    $display("test geometry done");
    busy = 1'b1;
    foreach (busy_cmds[i]) begin
      issue(busy_cmds[i], 22'h000000);
      chk({31'h0, refused}, 32'h1);
    end
    busy = 1'b0;
    issue(4'h3, 22'h000000);
    busy = 1'b1;
    timeout = 1'b1;
    issue(4'h9, 22'h000000);
    chk({31'h0, rdata[5]}, 32'h1);
    @(posedge ref_clk_i) #1;
    chk({31'h0, ready}, 32'h0);
    wait_end();
    chk({30'h0, dev_mode}, 32'h0);
    busy = 1'b0;
    timeout = 1'b0;
    $display("test busy done");
    cmd = 4'h1;
    cmd_valid = 1'b1;
    @(posedge ref_clk_i) #1 cmd_valid = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 nrst_i = 1'b0;
    #1 chk({ce_n, we_n, oe_n, dq_oe, ready, done, refused, mode}, 32'h000001d0);
    repeat (4) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    issue(4'h0, 22'h000123);
    chk(rdata, 32'h00005b79);
    $display("test abort done");
    summarize();
  end
endmodule // tb_top
